/* edge_detect.sv */
// edge and level logic over all lines, with one shared re-arm, for the keypad wake unit
`timescale 1ns/10ps
`default_nettype none
`include "kw_consts.svh"
module edge_detect (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // configuration and lines
  input  wire logic [`LINES-1:0]  lines,
  input  wire logic [`LINES-1:0]  enable,
  input  wire logic [`LINES-1:0]  polarity,
  // results
  output logic                    edge_hit,
  output logic                    any_asserted
);
  logic [`LINES-1:0] prev;
  logic [`LINES-1:0] next_prev;
  logic              armed;
  logic              next_armed;
  logic [`LINES-1:0] asserted_now;
  logic [`LINES-1:0] asserted_prev;

  // 0 means low level, 1 means high level
  always_comb begin
    asserted_now  = ~(lines ^ polarity);
    asserted_prev = ~(prev ^ polarity);
  end

  // edge is deasserted then asserted on consecutive cycles
  always_comb begin
    any_asserted = |(asserted_now & enable);
    edge_hit     = armed && |(asserted_now & ~asserted_prev & enable);
    next_prev    = lines;
    // re-arm only once every enabled line is deasserted
    if (!any_asserted) begin
      next_armed = 1'b1;
    end else if (edge_hit) begin
      next_armed = 1'b0;
    end else begin
      next_armed = armed;
    end
  end

  // armed stays low after reset until no enabled line is asserted, blocking spurious edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev  <= `RST_BYTE;
      armed <= 1'b0;
    end else begin
      prev  <= next_prev;
      armed <= next_armed;
    end
  end

  // a hit disarms, a held line keeps it disarmed
  disarm_on_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
    edge_hit |=> !armed)
    else $error("detector still armed after edge");
  held_disarmed_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!armed && any_asserted) |=> !armed)
    else $error("detector re-armed while line asserted");
endmodule : edge_detect
`default_nettype wire

/* key_switches.sv */
// key switch model with pad pull resistors on the keypad lines
`timescale 1ns/10ps
`default_nettype none
module key_switches (
  // clock
  input  wire logic       pclk,
  // switch contacts from the bench
  input  wire logic [7:0] drive_en,
  input  wire logic [7:0] drive_val,
  // pad control from the unit
  input  wire logic [7:0] pull_on,
  input  wire logic [7:0] pull_down,
  // lines
  output logic      [7:0] key_lines
);
  logic [7:0] wander = 8'h55;
  // a floating pin wanders, so no test can lean on a settled unknown
  always_ff @(posedge pclk) begin
    wander <= ~wander;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      key_lines[i] = drive_en[i] ? drive_val[i] : (pull_on[i] ? ~pull_down[i] : wander[i]);
    end
  end
endmodule : key_switches
`default_nettype wire

/* keypad_wake_unit.sv */
// keypad wake unit: apb registers, flag, interrupt, pull control
// Behaviour
// - eight lines, each with an enable bit that admits it to detection.
// - one mode bit selects edge-only or edge-and-level sensing for all lines.
// - each line has a polarity bit choosing falling/low or rising/high.
// - falling polarity detects an edge when a line goes from 1 to 0 on consecutive cycles.
// - rising polarity detects an edge when a line goes from 0 to 1 on consecutive cycles.
// - edge detection re-arms only when all enabled lines are deasserted.
// - in edge mode a valid edge sets the wake flag.
// - the cpu interrupt is high while the wake flag and its enable are both set.
// - in edge mode writing 1 to the acknowledge bit clears the flag.
// - in edge-and-level mode an edge or an asserted level sets the flag.
// - in edge-and-level mode acknowledge clears only if all enabled lines are deasserted.
// - with pull enabled, polarity 0 pulls up and polarity 1 pulls down.
// - mode bit 0 is edge-only and 1 is edge-plus-level.
// - polarity 0 is falling/low and 1 is rising/high.
// - writes to the flag position do nothing and acknowledge reads as zero.
`timescale 1ns/10ps
`default_nettype none
`include "kw_consts.svh"
module keypad_wake_unit
  import kw_pkg::*;
(
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // keypad lines and pad control
  input  wire logic [`LINES-1:0]  key_lines,
  output logic      [`LINES-1:0]  pull_on,
  output logic      [`LINES-1:0]  pull_down,
  // interrupts
  output logic                    wake_irq,
  output logic                    event_irq
);
  detect_mode_t      detect_mode_sel;
  logic              wake_irq_enable;
  logic              wake_flag;
  logic [`LINES-1:0] line_enable_reg;
  logic [`LINES-1:0] polarity_reg;
  logic [`LINES-1:0] port_pull_enable;
  logic [`EV_BITS-1:0] ev_status;
  logic [`EV_BITS-1:0] ev_enable;

  detect_mode_t      next_mode;
  logic              next_ie;
  logic              next_flag;
  logic [`LINES-1:0] next_line_en;
  logic [`LINES-1:0] next_pol;
  logic [`LINES-1:0] next_pull;
  logic [`EV_BITS-1:0] next_ev_status;
  logic [`EV_BITS-1:0] next_ev_enable;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic [`LINES-1:0] next_pull_on;
  logic [`LINES-1:0] next_pull_down;
  logic              next_wake_irq;
  logic              next_event_irq;

  logic [`LINES-1:0] lines_sync;
  logic              edge_hit;
  logic              any_asserted;
  logic              wr_access;
  logic              rd_access;
  logic              ack_write;
  logic              set_flag;
  logic              known;

  // address check, used by read and write paths
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFF_STATUS_CTRL) || (a == `OFF_LINE_EN) || (a == `OFF_POLARITY) ||
             (a == `OFF_PULL_EN) || (a == `OFF_IRQ_STATUS) || (a == `OFF_IRQ_ENABLE) ||
             (a == `OFF_IRQ_CLEAR);
  endfunction : mapped

  line_sync line_sync_i (
    .pclk     (pclk),
    .presetn  (presetn),
    .raw_in   (key_lines),
    .sync_out (lines_sync)
  );

  // all lines reach the detector, which masks them with line_enable_reg
  edge_detect edge_detect_i (
    .pclk         (pclk),
    .presetn      (presetn),
    .lines        (lines_sync),
    .enable       (line_enable_reg),
    .polarity     (polarity_reg),
    .edge_hit     (edge_hit),
    .any_asserted (any_asserted)
  );

  // apb answers in the access cycle: pready is registered high in the setup cycle
  // no wait states: the read mux works in setup, so data is in place when pready rises
  always_comb begin
    known     = mapped(paddr);
    wr_access = psel && penable && pready && pwrite;
    rd_access = psel && !penable && !pwrite;
    ack_write = wr_access && (paddr == `OFF_STATUS_CTRL) && pwdata[`BIT_ACK];
  end

  // one mode bit serves every line
  // mode 0 edge only, mode 1 adds level
  always_comb begin
    if (detect_mode_sel == MODE_EDGE_LEVEL) begin
      set_flag = edge_hit || any_asserted;
    end else begin
      set_flag = edge_hit;
    end
  end

  // register writes and flag update
  always_comb begin
    next_mode    = detect_mode_sel;
    next_ie      = wake_irq_enable;
    next_line_en = line_enable_reg;
    next_pol     = polarity_reg;
    next_pull    = port_pull_enable;
    next_ev_enable = ev_enable;
    next_ev_status = ev_status;
    next_flag    = wake_flag;
    if (wr_access) begin
      if (paddr == `OFF_STATUS_CTRL) begin
        next_mode = detect_mode_t'(pwdata[`BIT_MODE]);
        next_ie   = pwdata[`BIT_IE];
      end else if (paddr == `OFF_LINE_EN) begin
        next_line_en = pwdata[`LINES-1:0];
      end else if (paddr == `OFF_POLARITY) begin
        next_pol = pwdata[`LINES-1:0];
      end else if (paddr == `OFF_PULL_EN) begin
        next_pull = pwdata[`LINES-1:0];
      end else if (paddr == `OFF_IRQ_ENABLE) begin
        next_ev_enable = pwdata[`EV_BITS-1:0];
      end else if (paddr == `OFF_IRQ_CLEAR) begin
        next_ev_status = ev_status & ~pwdata[`EV_BITS-1:0];
      end
    end
    // events win over a clear in the same cycle
    next_ev_status[`EV_EDGE]  = next_ev_status[`EV_EDGE] | edge_hit;
    next_ev_status[`EV_LEVEL] = next_ev_status[`EV_LEVEL] |
                                (any_asserted && detect_mode_sel == MODE_EDGE_LEVEL);
    // level mode: clear only when no enabled line is asserted
    if (ack_write && !(detect_mode_sel == MODE_EDGE_LEVEL && any_asserted)) begin
      next_flag = 1'b0;
    end
    // a set in the acknowledge cycle is kept
    if (set_flag) begin
      next_flag = 1'b1;
    end
  end

  // read mux and bus answer
  always_comb begin
    next_prdata  = `RST_WORD;
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !known;
    if (rd_access) begin
      if (paddr == `OFF_STATUS_CTRL) begin
        next_prdata[`BIT_FLAG] = wake_flag;
        next_prdata[`BIT_IE]   = wake_irq_enable;
        next_prdata[`BIT_MODE] = detect_mode_sel;
      end else if (paddr == `OFF_LINE_EN) begin
        next_prdata[`LINES-1:0] = line_enable_reg;
      end else if (paddr == `OFF_POLARITY) begin
        next_prdata[`LINES-1:0] = polarity_reg;
      end else if (paddr == `OFF_PULL_EN) begin
        next_prdata[`LINES-1:0] = port_pull_enable;
      end else if (paddr == `OFF_IRQ_STATUS) begin
        next_prdata[`EV_BITS-1:0] = ev_status;
      end else if (paddr == `OFF_IRQ_ENABLE) begin
        next_prdata[`EV_BITS-1:0] = ev_enable;
      end
    end else if (psel && penable) begin
      next_prdata = prdata;
    end
  end

  // outputs computed from next state so they track registers with no lag
  always_comb begin
    next_pull_on   = next_pull;
    next_pull_down = next_pol & next_pull;
    // flag and enable drive the cpu request
    next_wake_irq  = next_flag && next_ie;
    next_event_irq = |(next_ev_status & next_ev_enable);
  end

  // registers only; every output of the unit leaves from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_mode_sel  <= MODE_EDGE;
      wake_irq_enable  <= 1'b0;
      wake_flag        <= 1'b0;
      line_enable_reg  <= `RST_BYTE;
      polarity_reg     <= `RST_BYTE;
      port_pull_enable <= `RST_BYTE;
      ev_status        <= '0;
      ev_enable        <= '0;
      prdata           <= `RST_WORD;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      pull_on          <= `RST_BYTE;
      pull_down        <= `RST_BYTE;
      wake_irq         <= 1'b0;
      event_irq        <= 1'b0;
    end else begin
      detect_mode_sel  <= next_mode;
      wake_irq_enable  <= next_ie;
      wake_flag        <= next_flag;
      line_enable_reg  <= next_line_en;
      polarity_reg     <= next_pol;
      port_pull_enable <= next_pull;
      ev_status        <= next_ev_status;
      ev_enable        <= next_ev_enable;
      prdata           <= next_prdata;
      pready           <= next_pready;
      pslverr          <= next_pslverr;
      pull_on          <= next_pull_on;
      pull_down        <= next_pull_down;
      wake_irq         <= next_wake_irq;
      event_irq        <= next_event_irq;
    end
  end

  // checks
  irq_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake_irq == (wake_flag && wake_irq_enable)) else $error("irq not equal flag and enable");
  edge_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    edge_hit |=> wake_flag) else $error("edge did not set flag");
  level_holds_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (any_asserted && detect_mode_sel == MODE_EDGE_LEVEL) |=> wake_flag) else $error("level flag lost");
  ack_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ack_write && !set_flag && detect_mode_sel == MODE_EDGE) |=> !wake_flag) else $error("ack did not clear");
  flag_no_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!set_flag && !ack_write) |=> wake_flag == $past(wake_flag)) else $error("flag changed without cause");
  ack_reads_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !prdata[`BIT_ACK] || $past(paddr) != `OFF_STATUS_CTRL) else $error("ack bit read as one");
  pull_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    pull_down == (polarity_reg & port_pull_enable)) else $error("pull direction wrong");
  disabled_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (line_enable_reg == `RST_BYTE) |-> !edge_hit && !any_asserted) else $error("disabled line detected");

  // mode bit taken from a status write
  mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == `OFF_STATUS_CTRL) |=> ((detect_mode_sel == MODE_EDGE_LEVEL) == $past(pwdata[`BIT_MODE])))
    else $error("mode bit not written");

  // enable bits taken from a write
  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == `OFF_LINE_EN) |=> line_enable_reg == $past(pwdata[`LINES-1:0]))
    else $error("line enable not written");

  // polarity bits taken from a write
  polarity_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == `OFF_POLARITY) |=> polarity_reg == $past(pwdata[`LINES-1:0]))
    else $error("polarity not written");

  // edge mode sets only on an edge
  edge_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (detect_mode_sel == MODE_EDGE && !edge_hit && !wake_flag) |=> !wake_flag)
    else $error("flag set without edge");

  // edge mode ack ignores held lines
  edge_ack_held_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ack_write && detect_mode_sel == MODE_EDGE && any_asserted && !edge_hit) |=> !wake_flag)
    else $error("held line blocked edge ack");

  // edge sets flag in level mode
  level_edge_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    (detect_mode_sel == MODE_EDGE_LEVEL && edge_hit) |=> wake_flag)
    else $error("edge lost in level mode");

  // ack refused while a line is asserted
  level_ack_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ack_write && detect_mode_sel == MODE_EDGE_LEVEL && any_asserted) |=> wake_flag)
    else $error("flag cleared with line asserted");

  // ack accepted once lines are idle
  level_ack_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ack_write && detect_mode_sel == MODE_EDGE_LEVEL && !any_asserted) |=> !wake_flag)
    else $error("idle ack did not clear");

  // a one in the flag position is ignored
  flag_write_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == `OFF_STATUS_CTRL && pwdata[`BIT_FLAG] && !set_flag && !wake_flag) |=> !wake_flag)
    else $error("flag set by a write");

  // pull enable passed to the pads
  pull_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    pull_on == port_pull_enable)
    else $error("pull enable wrong");
endmodule : keypad_wake_unit
`default_nettype wire

/* kw_consts.svh */
// constants of the keypad wake unit: register map, fields, reset values
`ifndef KW_CONSTS_SVH
`define KW_CONSTS_SVH
`define LINES          8
`define OFF_STATUS_CTRL 12'h000
`define OFF_LINE_EN     12'h004
`define OFF_POLARITY    12'h008
`define OFF_PULL_EN     12'h00C
`define OFF_IRQ_STATUS  12'h010
`define OFF_IRQ_ENABLE  12'h014
`define OFF_IRQ_CLEAR   12'h018
`define BIT_MODE        0
`define BIT_IE          1
`define BIT_ACK         2
`define BIT_FLAG        3
`define EV_EDGE         0
`define EV_LEVEL        1
`define EV_BITS         2
`define RST_BYTE        8'h00
`define RST_WORD        32'h0000_0000
`endif

/* kw_pkg.sv */
// types shared by the keypad wake unit
package kw_pkg;
  typedef enum logic {MODE_EDGE, MODE_EDGE_LEVEL} detect_mode_t;
endpackage : kw_pkg

/* line_sync.sv */
// two-flop synchroniser for the keypad input lines
`timescale 1ns/10ps
`default_nettype none
`include "kw_consts.svh"
module line_sync (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // lines
  input  wire logic [`LINES-1:0]  raw_in,
  output logic      [`LINES-1:0]  sync_out
);
  logic [`LINES-1:0] meta;
  logic [`LINES-1:0] next_meta;
  logic [`LINES-1:0] next_sync;

  // pins are asynchronous, so only the second flop is read
  always_comb begin
    next_meta = raw_in;
    next_sync = meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= `RST_BYTE;
      sync_out <= `RST_BYTE;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule : line_sync
`default_nettype wire

/* test_keypad_wake_unit.sv */
// self-checking bench for the keypad wake unit
`timescale 1ns/10ps
`default_nettype none
`include "kw_consts.svh"
module test_keypad_wake_unit;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        pready;
  logic        pslverr;
  logic        e;
  logic        wake_irq;
  logic        event_irq;
  logic [7:0]  key_lines;
  logic [7:0]  pull_on;
  logic [7:0]  pull_down;
  logic [7:0]  drive_en = 8'h00;
  logic [7:0]  drive_val = 8'h00;
  int          err_count = 0;
  int          n_checks = 0;
  // register rows: address, write value, readback, error response
  row_t rows[7] = '{
    '{`OFF_STATUS_CTRL, 32'h0000_000D, 32'h0000_0001, 1'b0},
    '{`OFF_LINE_EN,     32'h0000_01A5, 32'h0000_00A5, 1'b0},
    '{`OFF_POLARITY,    32'hFFFF_FF3C, 32'h0000_003C, 1'b0},
    '{`OFF_PULL_EN,     32'h0000_00C3, 32'h0000_00C3, 1'b0},
    '{`OFF_IRQ_ENABLE,  32'h0000_0003, 32'h0000_0003, 1'b0},
    '{`OFF_IRQ_CLEAR,   32'h0000_0003, 32'h0000_0000, 1'b0},
    '{12'h01C,          32'h0000_00FF, 32'h0000_0000, 1'b1}};

  // clock at 20 MHz
  always #25 pclk = ~pclk;

  keypad_wake_unit keypad_wake_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_lines(key_lines), .pull_on(pull_on), .pull_down(pull_down), .wake_irq(wake_irq),
    .event_irq(event_irq));

  key_switches key_switches_i (.pclk(pclk), .drive_en(drive_en), .drive_val(drive_val),
    .pull_on(pull_on), .pull_down(pull_down), .key_lines(key_lines));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one apb transfer; entered just after a rising edge, an idle edge follows
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      final_report();
    end
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // change the switches, then let sync, compare, flag and irq stages settle
  task automatic pin(input logic [7:0] en, input logic [7:0] v);
    drive_en <= en;
    drive_val <= v;
    repeat (8) @(posedge pclk);
  endtask : pin

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge pclk);
    chk("wake_irq", {31'h0, exp}, {31'h0, wake_irq});
  endtask : irq_is

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // ordinary register cases
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk("write error", {31'h0, rows[i].e}, {31'h0, e});
      apb(1'b0, rows[i].a, 32'h0);
      chk("readback", rows[i].r, q);
    end
    // reset in mid-run returns every register to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0);
      chk("reset value", `RST_WORD, q);
    end
    // safe set-up order, falling polarity on line 0
    wr(`OFF_STATUS_CTRL, 32'h0);
    wr(`OFF_POLARITY, 32'h0);
    wr(`OFF_PULL_EN, 32'hFF);
    chk("pull_on", 32'hFF, {24'h0, pull_on});
    wr(`OFF_LINE_EN, 32'h01);
    wr(`OFF_STATUS_CTRL, 32'h4);
    wr(`OFF_STATUS_CTRL, 32'h2);
    wr(`OFF_IRQ_ENABLE, 32'h1);
    irq_is(1'b0);
    pin(8'h01, 8'h00);
    irq_is(1'b1);
    apb(1'b0, `OFF_STATUS_CTRL, 32'h0);
    chk("flag and enable", 32'h0000_000A, q);
    chk("event_irq", 32'h1, {31'h0, event_irq});
    wr(`OFF_STATUS_CTRL, 32'h6);
    irq_is(1'b0);
    // a second line falls while line 0 is held: the detector stays disarmed
    wr(`OFF_LINE_EN, 32'h03);
    pin(8'h03, 8'h00);
    irq_is(1'b0);
    pin(8'h01, 8'h00);
    wr(`OFF_LINE_EN, 32'h01);
    wr(`OFF_IRQ_CLEAR, 32'h1);
    chk("event_irq", 32'h0, {31'h0, event_irq});
    pin(8'h02, 8'h00);
    irq_is(1'b0);
    pin(8'h01, 8'h00);
    irq_is(1'b1);
    wr(`OFF_STATUS_CTRL, 32'h0);
    irq_is(1'b0);
    // rising polarity with pull-down
    pin(8'h00, 8'h00);
    wr(`OFF_POLARITY, 32'h01);
    chk("pull_down", 32'h01, {24'h0, pull_down});
    wr(`OFF_STATUS_CTRL, 32'h6);
    irq_is(1'b0);
    pin(8'h01, 8'h01);
    irq_is(1'b1);
    // held level: edge-mode ack clears, then level mode sets again
    wr(`OFF_STATUS_CTRL, 32'h6);
    irq_is(1'b0);
    wr(`OFF_STATUS_CTRL, 32'h3);
    irq_is(1'b1);
    wr(`OFF_STATUS_CTRL, 32'h7);
    apb(1'b0, `OFF_STATUS_CTRL, 32'h0);
    chk("flag kept", 32'h0000_000B, q);
    pin(8'h00, 8'h00);
    wr(`OFF_STATUS_CTRL, 32'h7);
    irq_is(1'b0);
    // a fresh edge in level mode sets the flag; both event bits stand
    pin(8'h01, 8'h01);
    irq_is(1'b1);
    apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
    chk("event status", 32'h0000_0003, q);
    final_report();
  end
endmodule : test_keypad_wake_unit
`default_nettype wire
